// *** logic/radio_frame_energy_sync_ctrl.sv ***
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "radio_frame_map.svh"
module radio_frame_energy_sync_ctrl #(
  parameter int SYNC_BITS = 32
) (
  input  wire logic                  SYS_CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [11:0]           PADDR,
  input  wire logic [31:0]           PWDATA,
  output logic      [31:0]           PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  RADIO_RX_ON,
  input  wire logic [7:0]            ENERGY_SAMPLE,
  input  wire logic                  ENERGY_SAMPLE_VALID,
  input  wire logic                  RX_BIT,
  input  wire logic                  RX_BIT_VALID,
  input  wire logic [SYNC_BITS-1:0]  SYNC_WORD,
  input  wire logic                  RX_FIFO_READ,
  output logic                       SYNC_DETECT,
  input  wire logic                  TX_START,
  input  wire logic                  TX_BIT_TICK,
  input  wire logic                  TX_PAYLOAD_BIT,
  input  wire logic                  TX_PAYLOAD_LAST,
  output logic                       TX_PAYLOAD_READ,
  output logic                       TX_DATA,
  output logic                       TX_DATA_VALID,
  output logic                       TX_BUSY,
  output radio_frame_pkg::irq_vec_t  IRQ_PENDING,
  output logic                       INTERRUPT
);
  import radio_frame_pkg::*;

  if (SYNC_BITS < 8 || SYNC_BITS > 32) begin : g_bad_sync
    $error("SYNC_BITS must lie between 8 and 32");
  end

  // Register file
  logic [7:0]     energy_ctrl;
  logic [7:0]     pre_high;
  logic [7:0]     pre_low;
  logic [7:0]     post_cfg;
  logic [7:0]     sync_cfg;
  logic [7:0]     sync_threshold;
  logic [7:0]     energy_result;
  irq_vec_t       irq_status;
  irq_vec_t       irq_enable;

  wire        apb_access = PSEL && PENABLE && !PREADY;
  wire        apb_commit = PSEL && PENABLE && PREADY;
  wire [7:0]  reg_index  = PADDR[9:2];
  wire        addr_high  = |PADDR[11:10];
  wire        sel_result = !addr_high && reg_index == `IDX_ENERGY_RESULT;
  wire        sel_ectrl  = !addr_high && reg_index == `IDX_ENERGY_CTRL;
  wire        sel_prehi  = !addr_high && reg_index == `IDX_TX_PRE_HIGH;
  wire        sel_prelo  = !addr_high && reg_index == `IDX_TX_PRE_LOW;
  wire        sel_post   = !addr_high && reg_index == `IDX_POSTAMBLE_CFG;
  wire        sel_sync   = !addr_high && reg_index == `IDX_SYNC_COND_CFG;
  wire        sel_thr    = !addr_high && reg_index == `IDX_SYNC_THRESHOLD;
  wire        sel_ist    = !addr_high && reg_index == `IDX_IRQ_STATUS;
  wire        sel_ien    = !addr_high && reg_index == `IDX_IRQ_ENABLE;
  wire        sel_iclr   = !addr_high && reg_index == `IDX_IRQ_CLEAR;
  wire        mapped     = sel_result | sel_ectrl | sel_prehi | sel_prelo | sel_post |
                           sel_sync | sel_thr | sel_ist | sel_ien | sel_iclr;
  wire        wr         = apb_commit && PWRITE && mapped;
  // Reserved bits are dropped on write so they keep reading as zero
  wire [7:0]  ectrl_wmask = 8'h8f;
  wire [7:0]  post_wmask  = 8'h77;
  wire [7:0]  sync_wmask  = 8'hbf;

  logic       calc_complete;
  wire [7:0]  ectrl_view = {energy_ctrl[7:5], calc_complete, energy_ctrl[3:0]};
  wire [7:0]  read_mux   = sel_result ? energy_result :
                           sel_ectrl  ? ectrl_view :
                           sel_prehi  ? pre_high :
                           sel_prelo  ? pre_low :
                           sel_post   ? post_cfg :
                           sel_sync   ? sync_cfg :
                           sel_thr    ? sync_threshold :
                           sel_ist    ? {5'h00, irq_status} :
                           sel_ien    ? {5'h00, irq_enable} : 8'h00;

  // Answer one cycle into the access phase
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= apb_access;
      PSLVERR <= apb_access && !mapped;
      if (apb_access) begin
        PRDATA <= (PWRITE || !mapped) ? 32'h0000_0000 : {24'h000000, read_mux};
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      energy_ctrl    <= `RST_ENERGY_CTRL;
      pre_high       <= `RST_TX_PRE_HIGH;
      pre_low        <= `RST_TX_PRE_LOW;
      post_cfg       <= `RST_POSTAMBLE_CFG;
      sync_cfg       <= `RST_SYNC_COND_CFG;
      sync_threshold <= `RST_SYNC_THRESHOLD;
      irq_enable     <= 3'h0;
    end else if (wr) begin
      if (sel_ectrl) energy_ctrl <= PWDATA[7:0] & ectrl_wmask & 8'hef;
      if (sel_prehi) pre_high <= PWDATA[7:0];
      if (sel_prelo) pre_low <= PWDATA[7:0];
      if (sel_post) post_cfg <= PWDATA[7:0] & post_wmask;
      if (sel_sync) sync_cfg <= PWDATA[7:0] & sync_wmask;
      if (sel_thr) sync_threshold <= PWDATA[7:0];
      if (sel_ien) irq_enable <= PWDATA[2:0];
    end
  end

  // Energy averaging
  wire        calc_enable   = energy_ctrl[`BIT_CALC_ENABLE];
  wire        capture_mode  = energy_ctrl[`BIT_CAPTURE_MODE];
  wire [2:0]  avg_code      = energy_ctrl[`AVG_MSB:0];
  wire        calc_active   = calc_enable && RADIO_RX_ON;
  wire [2:0]  avg_shift     = (avg_code <= 3'h5) ? avg_code : 3'h4;
  wire [5:0]  avg_last      = 6'((6'h01 << avg_shift) - 6'h01);
  logic [12:0] energy_sum;
  logic [5:0]  sample_count;
  logic [7:0]  energy_avg;
  logic [7:0]  sync_capture;
  wire         window_end   = calc_active && ENERGY_SAMPLE_VALID && sample_count == avg_last;
  wire [12:0]  window_total = energy_sum + {5'h00, ENERGY_SAMPLE};
  wire [12:0]  window_mean  = window_total >> avg_shift;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST || !calc_active) begin
      energy_sum   <= 13'h0000;
      sample_count <= 6'h00;
    end else if (ENERGY_SAMPLE_VALID) begin
      energy_sum   <= window_end ? 13'h0000 : window_total;
      sample_count <= window_end ? 6'h00 : sample_count + 6'h01;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      calc_complete <= 1'b0;
      energy_avg    <= 8'h00;
    end else if (window_end) begin
      calc_complete <= 1'b1;
      energy_avg    <= window_mean[7:0];
    end else if (calc_active && ENERGY_SAMPLE_VALID && sample_count == 6'h00) begin
      calc_complete <= 1'b0;
    end
  end

  // Reported result: live, or captured at sync and released by a FIFO read
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      sync_capture  <= 8'h00;
      energy_result <= 8'h00;
    end else begin
      if (SYNC_DETECT) sync_capture <= energy_avg;
      if (!capture_mode && window_end) begin
        energy_result <= window_mean[7:0];
      end else if (capture_mode && RX_FIFO_READ) begin
        energy_result <= sync_capture;
      end
    end
  end

  // Sync correlator over preamble extension plus sync word
  logic [SYNC_BITS+31:0] rx_history;
  logic                  rx_fresh;
  wire [5:0]  pre_len_raw  = sync_cfg[`RX_PRE_LEN_MSB:0];
  wire [5:0]  pre_len      = (pre_len_raw > `RX_PRE_MAX) ? `RX_PRE_MAX : pre_len_raw;
  wire [32:0] pre_mask_w   = 33'((33'h1 << pre_len) - 33'h1);
  wire [31:0] pre_mask     = pre_mask_w[31:0];
  // Preamble ahead of the sync word is the alternating pattern ending in one
  wire [31:0] pre_err      = (rx_history[SYNC_BITS+31:SYNC_BITS] ^ 32'h5555_5555) & pre_mask;
  wire        word_match   = rx_history[SYNC_BITS-1:0] == SYNC_WORD && pre_err == 32'h0000_0000;
  wire        energy_ok    = !sync_cfg[`BIT_SYNC_ENERGY_EN] || energy_avg > sync_threshold;
  wire        sync_hit     = rx_fresh && RADIO_RX_ON && word_match && energy_ok;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rx_history  <= '0;
      rx_fresh    <= 1'b0;
      SYNC_DETECT <= 1'b0;
    end else begin
      if (RX_BIT_VALID) rx_history <= {rx_history[SYNC_BITS+30:0], RX_BIT};
      rx_fresh    <= RX_BIT_VALID;
      SYNC_DETECT <= sync_hit;
    end
  end

  // Transmit framing
  tx_state_t  tx_state;
  tx_state_t  next_tx_state;
  logic [16:0] bit_index;
  logic [1:0]  last_bits;
  logic        tx_done;
  wire [16:0] pre_total    = {pre_high, pre_low, 1'b0};
  wire [2:0]  trailer_len  = post_cfg[`TRAILER_LEN_MSB:`TRAILER_LEN_LSB];
  wire [1:0]  trailer_pat  = post_cfg[`TRAILER_PAT_MSB:`TRAILER_PAT_LSB];
  wire        trailer_on   = post_cfg[`BIT_TRAILER_EN] && trailer_len != 3'h0;
  wire [16:0] post_total   = {13'h0000, trailer_len, 1'b0};
  wire        crc_bit      = bit_index[1] ^ (bit_index[0] ? last_bits[0] : last_bits[1]);
  // Reserved code 11 falls back to the code 00 pattern
  wire        trailer_bit  = (trailer_pat == 2'b01) ? !bit_index[0] :
                             (trailer_pat == 2'b10) ? crc_bit : bit_index[0];
  wire        pre_end      = bit_index == pre_total - 17'h1;
  wire        post_end     = bit_index == post_total - 17'h1;

  always_comb begin
    next_tx_state = tx_state;
    unique case (tx_state)
      TX_IDLE:     if (TX_START) next_tx_state = (pre_total == 17'h0) ? TX_PAYLOAD : TX_PREAMBLE;
      TX_PREAMBLE: if (TX_BIT_TICK && pre_end) next_tx_state = TX_PAYLOAD;
      TX_PAYLOAD:  if (TX_BIT_TICK && TX_PAYLOAD_LAST) next_tx_state = trailer_on ? TX_TRAILER : TX_IDLE;
      TX_TRAILER:  if (TX_BIT_TICK && post_end) next_tx_state = TX_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      tx_state        <= TX_IDLE;
      bit_index       <= 17'h0;
      last_bits       <= 2'b00;
      TX_DATA         <= 1'b0;
      TX_DATA_VALID   <= 1'b0;
      TX_PAYLOAD_READ <= 1'b0;
      TX_BUSY         <= 1'b0;
      tx_done         <= 1'b0;
    end else begin
      tx_state        <= next_tx_state;
      TX_BUSY         <= next_tx_state != TX_IDLE;
      TX_DATA_VALID   <= TX_BIT_TICK && tx_state != TX_IDLE;
      TX_PAYLOAD_READ <= TX_BIT_TICK && tx_state == TX_PAYLOAD;
      tx_done         <= tx_state != TX_IDLE && next_tx_state == TX_IDLE;
      if (next_tx_state != tx_state) begin
        bit_index <= 17'h0;
      end else if (TX_BIT_TICK) begin
        bit_index <= bit_index + 17'h1;
      end
      if (TX_BIT_TICK) begin
        unique case (tx_state)
          TX_PREAMBLE: TX_DATA <= bit_index[0];
          TX_PAYLOAD: begin
            TX_DATA   <= TX_PAYLOAD_BIT;
            last_bits <= {last_bits[0], TX_PAYLOAD_BIT};
          end
          TX_TRAILER:  TX_DATA <= trailer_bit;
          TX_IDLE:     TX_DATA <= 1'b0;
        endcase
      end
    end
  end

  // Interrupts: set beats a simultaneous clear so no event is lost
  wire [2:0] irq_events = {tx_done, SYNC_DETECT, window_end};
  wire [2:0] irq_clear  = (wr && sel_iclr) ? PWDATA[2:0] : 3'h0;

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_status  <= 3'h0;
      IRQ_PENDING <= 3'h0;
      INTERRUPT   <= 1'b0;
    end else begin
      irq_status  <= (irq_status & ~irq_clear) | irq_events;
      IRQ_PENDING <= irq_status & irq_enable;
      INTERRUPT   <= |(irq_status & irq_enable);
    end
  end

  a_calc_gated: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    !calc_active |=> energy_sum == 13'h0 && sample_count == 6'h0)
    else $error("energy accumulated while calculation stopped");
  a_done_flag: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    window_end |=> ectrl_view[4])
    else $error("completion flag not set after window");
  a_live_result: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    window_end && !capture_mode |=> energy_result == $past(window_mean[7:0]))
    else $error("live energy result not refreshed");
  a_capture_hold: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    capture_mode && !RX_FIFO_READ |=> $stable(energy_result))
    else $error("captured result changed without fifo read");
  a_avg_limit: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    calc_active && ENERGY_SAMPLE_VALID && avg_code > 3'h5 |-> sample_count <= 6'h0f)
    else $error("averaging window exceeds sixteen");
  a_preamble_len: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    tx_state == TX_PREAMBLE |-> bit_index < pre_total)
    else $error("preamble ran past programmed length");
  a_trailer_len: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    tx_state == TX_TRAILER |-> bit_index < post_total)
    else $error("postamble ran past programmed length");
  a_trailer_enable: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    tx_state == TX_PAYLOAD && !post_cfg[0] |=> tx_state != TX_TRAILER)
    else $error("postamble sent while disabled");
  a_sync_energy: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_DETECT && $past(sync_cfg[7]) |-> $past(energy_avg) > $past(sync_threshold))
    else $error("sync declared below energy threshold");
  a_sync_match: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_DETECT |-> $past(pre_err) == 32'h0 && $past(pre_len) <= 6'h20)
    else $error("sync declared with preamble mismatch");
  a_irq_sticky: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    SYNC_DETECT |=> irq_status[1])
    else $error("sync event lost from status");
  a_reserved_zero: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
    energy_ctrl[6:4] == 3'h0 && post_cfg[7] == 1'b0 && post_cfg[3] == 1'b0 && sync_cfg[6] == 1'b0)
    else $error("reserved control bit set");
  c_sync: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) SYNC_DETECT);
  c_trailer: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) tx_state == TX_TRAILER ##1 tx_state == TX_IDLE);
  c_capture: cover property (@(posedge SYS_CLK) disable iff (SYS_RST) capture_mode && RX_FIFO_READ);
endmodule
`default_nettype wire

// *** logic/radio_frame_map.svh ***
`ifndef RADIO_FRAME_MAP_SVH
`define RADIO_FRAME_MAP_SVH
// Register indexes; byte address is four times the index
`define IDX_ENERGY_RESULT      8'h3a
`define IDX_ENERGY_CTRL        8'h41
`define IDX_TX_PRE_HIGH        8'h42
`define IDX_TX_PRE_LOW         8'h43
`define IDX_POSTAMBLE_CFG      8'h44
`define IDX_SYNC_COND_CFG      8'h45
`define IDX_SYNC_THRESHOLD     8'h46
`define IDX_IRQ_STATUS         8'h50
`define IDX_IRQ_ENABLE         8'h51
`define IDX_IRQ_CLEAR          8'h52
// Reset values
`define RST_ENERGY_CTRL        8'h83
`define RST_TX_PRE_HIGH        8'h00
`define RST_TX_PRE_LOW         8'h10
`define RST_POSTAMBLE_CFG      8'h10
`define RST_SYNC_COND_CFG      8'h08
`define RST_SYNC_THRESHOLD     8'h00
// Field positions
`define BIT_CALC_ENABLE        7
`define BIT_CALC_COMPLETE      4
`define BIT_CAPTURE_MODE       3
`define AVG_MSB                2
`define TRAILER_LEN_MSB        6
`define TRAILER_LEN_LSB        4
`define TRAILER_PAT_MSB        2
`define TRAILER_PAT_LSB        1
`define BIT_TRAILER_EN         0
`define BIT_SYNC_ENERGY_EN     7
`define RX_PRE_LEN_MSB         5
`define RX_PRE_MAX             6'h20
// Interrupt status bits
`define IRQ_ENERGY_DONE        0
`define IRQ_SYNC_FOUND         1
`define IRQ_TX_DONE            2
`endif

// *** logic/radio_frame_pkg.sv ***
package radio_frame_pkg;
  typedef enum logic [1:0] {
    TX_IDLE     = 2'b00,
    TX_PREAMBLE = 2'b01,
    TX_PAYLOAD  = 2'b11,
    TX_TRAILER  = 2'b10
  } tx_state_t;
  typedef logic [2:0] irq_vec_t;
endpackage

// *** verification/remote_radio_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module remote_radio_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic tx_busy,
  input  wire logic tx_data,
  input  wire logic tx_valid,
  input  wire logic pay_read,
  input  wire logic sync_detect,
  output logic      tick,
  output logic      pay_bit,
  output logic      pay_last,
  output logic      rx_bit,
  output logic      rx_valid
);
  localparam logic [3:0] PAYLOAD = 4'b1101;
  logic [1:0]  div;
  logic [1:0]  pidx;
  logic [63:0] capv;
  int          ncap = 0;
  int          nsync = 0;
  assign pay_bit  = PAYLOAD[2'd3 - pidx];
  assign pay_last = (pidx == 2'd3);
  initial begin
    rx_bit   = 1'b0;
    rx_valid = 1'b0;
  end
  // Bit strobe only while a frame is running; a slow air rate of one bit per four clocks
  always @(posedge clk) begin
    if (rst || !tx_busy) begin
      div  <= 2'd0;
      tick <= 1'b0;
      pidx <= 2'd0;
    end else begin
      div  <= div + 2'd1;
      tick <= (div == 2'd3);
      if (pay_read) begin
        pidx <= pidx + 2'd1;
      end
    end
    if (tx_valid) begin
      capv <= {capv[62:0], tx_data};
      ncap <= ncap + 1;
    end
    if (sync_detect) begin
      nsync <= nsync + 1;
    end
  end
  // Oldest bit first; between bits the line shows the inverse so a stale level never matches
  task automatic send(input logic [63:0] v, input int n);
    int i;
    for (i = n - 1; i >= 0; i--) begin
      @(posedge clk);
      rx_bit   <= v[i];
      rx_valid <= 1'b1;
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_bit   <= ~v[i];
    end
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// *** verification/radio_frame_energy_sync_ctrl_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "radio_frame_map.svh"
module radio_frame_energy_sync_ctrl_tb_top;
  import radio_frame_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, e;
  logic        rx_on, svalid, fifo_rd, start, rxb, rxv, sync_det;
  logic        tick, pbit, plast, pread, txd, txv, busy, intr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [7:0]  sample;
  irq_vec_t    pend;
  int          miscompares = 0;
  int          n_tests = 0;
  int          c, s, last, n0, k;
  int          avg_n [8] = '{1, 2, 4, 8, 16, 32, 16, 16};
  logic [3:0]  trl [4] = '{4'h5, 4'ha, 4'h6, 4'h5};
  radio_frame_energy_sync_ctrl dut_u (
    .SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RADIO_RX_ON(rx_on), .ENERGY_SAMPLE(sample), .ENERGY_SAMPLE_VALID(svalid),
    .RX_BIT(rxb), .RX_BIT_VALID(rxv), .SYNC_WORD(32'h2dd4_1ace), .RX_FIFO_READ(fifo_rd),
    .SYNC_DETECT(sync_det), .TX_START(start), .TX_BIT_TICK(tick), .TX_PAYLOAD_BIT(pbit),
    .TX_PAYLOAD_LAST(plast), .TX_PAYLOAD_READ(pread), .TX_DATA(txd), .TX_DATA_VALID(txv),
    .TX_BUSY(busy), .IRQ_PENDING(pend), .INTERRUPT(intr));
  remote_radio_model model_u (
    .clk(clk), .rst(rst), .tx_busy(busy), .tx_data(txd), .tx_valid(txv), .pay_read(pread),
    .sync_detect(sync_det), .tick(tick), .pay_bit(pbit), .pay_last(plast), .rx_bit(rxb), .rx_valid(rxv));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i == 20) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, {24'h0, d}, rdv, e);
  endtask
  task automatic rchk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0, rdv, e);
    check(what, exp, rdv);
  endtask
  task automatic feed(input int base, input int step, input int n, inout int sum);
    int i;
    for (i = 0; i < n; i++) begin
      @(posedge clk);
      sample <= 8'(base + i * step);
      svalid <= 1'b1;
      sum += (base + i * step) & 255;
      @(posedge clk);
      svalid <= 1'b0;
    end
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse_start();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic sync_try(input string what, input logic [63:0] v, input int n, input int exp);
    k = model_u.nsync;
    model_u.send(v, n);
    check(what, exp, model_u.nsync - k);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    rx_on = 1'b0;
    sample = 8'h0;
    svalid = 1'b0;
    fifo_rd = 1'b0;
    start = 1'b0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rchk("energy ctrl", `IDX_ENERGY_CTRL, 32'h83);
    rchk("pre high", `IDX_TX_PRE_HIGH, 32'h00);
    rchk("pre low", `IDX_TX_PRE_LOW, 32'h10);
    rchk("postamble", `IDX_POSTAMBLE_CFG, 32'h10);
    rchk("sync cond", `IDX_SYNC_COND_CFG, 32'h08);
    wr(`IDX_POSTAMBLE_CFG, 8'hff);
    rchk("post reserved", `IDX_POSTAMBLE_CFG, 32'h77);
    wr(`IDX_SYNC_COND_CFG, 8'hff);
    rchk("sync reserved", `IDX_SYNC_COND_CFG, 32'hbf);
    apb(1'b0, 8'h60, 32'h0, rdv, e);
    check("unmapped err", 1, e);
    check("unmapped data", 0, rdv);
    $display("register test done");
    for (c = 0; c < 8; c++) begin
      // Radio off while the averaging count changes, so no window is running
      rx_on <= 1'b0;
      wr(`IDX_ENERGY_CTRL, 8'(c));
      rx_on <= 1'b1;
      wr(`IDX_ENERGY_CTRL, 8'(8'h80 | c));
      s = 0;
      feed(c * 9, 7, avg_n[c] - 1, s);
      if (avg_n[c] > 1) rchk("calc running", `IDX_ENERGY_CTRL, 32'h80 | c);
      feed(c * 9 + 7 * (avg_n[c] - 1), 7, 1, s);
      rchk("calc complete", `IDX_ENERGY_CTRL, 32'h90 | c);
      last = s / avg_n[c];
      rchk("average", `IDX_ENERGY_RESULT, last);
    end
    rx_on <= 1'b0;
    wr(`IDX_ENERGY_CTRL, 8'h03);
    rx_on <= 1'b1;
    feed(8'hf0, 0, 4, s);
    rchk("calc stopped", `IDX_ENERGY_RESULT, last);
    rchk("irq status", `IDX_IRQ_STATUS, 32'h1);
    wr(`IDX_IRQ_ENABLE, 8'h01);
    repeat (3) @(posedge clk);
    check("interrupt on", 1, intr);
    check("irq pending on", 1, pend);
    wr(`IDX_IRQ_CLEAR, 8'h01);
    repeat (3) @(posedge clk);
    check("interrupt off", 0, intr);
    check("irq pending off", 0, pend);
    $display("energy test done");
    wr(`IDX_TX_PRE_HIGH, 8'h00);
    wr(`IDX_TX_PRE_LOW, 8'h10);
    for (c = 0; c < 5; c++) begin
      wr(`IDX_POSTAMBLE_CFG, 8'(8'h20 | ((c & 3) << 1) | (c < 4)));
      n0 = model_u.ncap;
      pulse_start();
      if (c == 0) begin
        repeat (20) @(posedge clk);
        pulse_start();
      end
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (busy !== 1'b0 && k < 2000);
      if (k == 2000) begin
        miscompares++;
        test_done();
      end
      repeat (2) @(posedge clk);
      check("tx bits", (c < 4) ? 40 : 36, model_u.ncap - n0);
      if (c < 4) check("tx frame", {32'h5555_5555, 4'hd, trl[c]}, model_u.capv[39:0]);
      else check("tx frame", {32'h5555_5555, 4'hd}, model_u.capv[35:0]);
    end
    $display("transmit test done");
    wr(`IDX_SYNC_COND_CFG, 8'h08);
    sync_try("sync pre8", {8'h55, 32'h2dd4_1ace}, 40, 1);
    sync_try("sync bad pre8", {8'h00, 32'h2dd4_1ace}, 40, 0);
    wr(`IDX_SYNC_COND_CFG, 8'h00);
    sync_try("sync pre0", {8'h00, 32'h2dd4_1ace}, 40, 1);
    wr(`IDX_SYNC_COND_CFG, 8'h28);
    sync_try("sync pre32", {32'h5555_5555, 32'h2dd4_1ace}, 64, 1);
    sync_try("sync pre24", {32'h0055_5555, 32'h2dd4_1ace}, 64, 0);
    wr(`IDX_ENERGY_CTRL, 8'h80);
    feed(8'h40, 0, 1, s);
    wr(`IDX_SYNC_COND_CFG, 8'h80);
    wr(`IDX_SYNC_THRESHOLD, 8'h40);
    sync_try("sync at thr", {8'h00, 32'h2dd4_1ace}, 40, 0);
    wr(`IDX_SYNC_THRESHOLD, 8'h3f);
    sync_try("sync above thr", {8'h00, 32'h2dd4_1ace}, 40, 1);
    wr(`IDX_SYNC_THRESHOLD, 8'hff);
    wr(`IDX_SYNC_COND_CFG, 8'h00);
    sync_try("sync no check", {8'h00, 32'h2dd4_1ace}, 40, 1);
    wr(`IDX_ENERGY_CTRL, 8'h88);
    feed(8'h30, 0, 1, s);
    sync_try("sync capture", {8'h00, 32'h2dd4_1ace}, 40, 1);
    feed(8'h20, 0, 1, s);
    rchk("held result", `IDX_ENERGY_RESULT, 32'h40);
    @(posedge clk);
    fifo_rd <= 1'b1;
    @(posedge clk);
    fifo_rd <= 1'b0;
    rchk("captured result", `IDX_ENERGY_RESULT, 32'h30);
    rchk("irq all", `IDX_IRQ_STATUS, 32'h7);
    $display("receive test done");
    test_done();
  end
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
`default_nettype wire
